/* File: core/lbs_pkg.sv */
// lbs_pkg: constants for the lcd bias supply control block
// assumes a 40 MHz core clock and byte registers over a two-wire serial port
package lbs_pkg;
  // register offsets
  localparam logic [7:0] ADDR_ENABLE_CFG = 8'h09;
  localparam logic [7:0] ADDR_RAMP_SHORT = 8'h0a;
  localparam logic [7:0] ADDR_FILTER_CFG = 8'h0b;
  localparam logic [7:0] ADDR_BOOST_V    = 8'h0c;
  localparam logic [7:0] ADDR_POS_V      = 8'h0d;
  localparam logic [7:0] ADDR_NEG_V      = 8'h0e;
  localparam logic [7:0] ADDR_FLAGS      = 8'h0f;
  // reset values
  localparam logic [7:0] RST_ENABLE_CFG = 8'h18;
  localparam logic [7:0] RST_RAMP_SHORT = 8'h11;
  localparam logic [7:0] RST_FILTER_CFG = 8'h00;
  localparam logic [7:0] RST_BOOST_V    = 8'h28;
  localparam logic [7:0] RST_POS_V      = 8'h1e;
  localparam logic [7:0] RST_NEG_V      = 8'h1c;
  // writable bits
  localparam logic [7:0] MASK_FILTER = 8'h33;
  localparam logic [7:0] MASK_CODE   = 8'h3f;
  // enable cfg fields
  localparam int MODE_MSB     = 7;
  localparam int MODE_LSB     = 5;
  localparam int BIT_POS_DIS  = 4;
  localparam int BIT_NEG_DIS  = 3;
  localparam int BIT_POS_EN   = 2;
  localparam int BIT_NEG_EN   = 1;
  localparam int BIT_PIN_SEL  = 0;
  // ramp/short cfg fields
  localparam int SHORT_MSB    = 7;
  localparam int SHORT_LSB    = 6;
  localparam int PRAMP_MSB    = 5;
  localparam int PRAMP_LSB    = 4;
  localparam int NRAMP_MSB    = 3;
  localparam int NRAMP_LSB    = 0;
  // filter cfg fields
  localparam int PFILT_LSB    = 4;
  localparam int NFILT_LSB    = 0;
  // flags fields
  localparam int FLAG_POS     = 3;
  localparam int FLAG_NEG     = 2;
  // mode codes
  localparam logic [2:0] MODE_OFF    = 3'h0;
  localparam logic [2:0] MODE_NORMAL = 3'h4;
  localparam logic [2:0] MODE_AUTO   = 3'h5;
  localparam logic [2:0] MODE_FIRST_WAKE_MODE  = 3'h6;
  localparam logic [2:0] MODE_SECOND_WAKE_MODE  = 3'h7;
  // code saturation
  localparam logic [5:0] CODE_MAX = 6'h32;
  // timing
  localparam int CLK_MHZ        = 40;
  localparam int FILT_2MS_US    = 2000;
  localparam int FILT_1MS_US    = 1000;
  localparam int FILT_500US_US  = 500;
  localparam int FILT_100US_US  = 100;
  localparam int RAMP_POS_US    = 256;
  localparam int RAMP_NEG_US    = 512;
  localparam int FILT_2MS_CYC   = FILT_2MS_US * CLK_MHZ;
  localparam int FILT_1MS_CYC   = FILT_1MS_US * CLK_MHZ;
  localparam int FILT_500US_CYC = FILT_500US_US * CLK_MHZ;
  localparam int FILT_100US_CYC = FILT_100US_US * CLK_MHZ;
  localparam int RAMP_POS_CYC   = RAMP_POS_US * CLK_MHZ;
  localparam int RAMP_NEG_CYC   = RAMP_NEG_US * CLK_MHZ;
  // serial port device address, value arbitrary
  localparam logic [6:0] DEV_ADDR = 7'h2a;
  typedef enum logic [2:0] {
    LBS_IDLE, LBS_DEV, LBS_DACK, LBS_WBYTE, LBS_WACK, LBS_RBYTE, LBS_RACK
  } lbs_ser_e;
endpackage

/* File: core/lbs_serial_port.sv */
// lbs_serial_port: two-wire serial slave giving byte register access
// assumes scl/sda come from pins; sda is open drain, driven only low
`timescale 1ns/10ps
`default_nettype none
module lbs_serial_port (
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  // serial pins
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  output logic            o_sda_out,
  output logic            o_sda_oe,
  // register side
  output logic [7:0]      o_addr,
  output logic [7:0]      o_wdata,
  output logic            o_wr,
  output logic            o_rd,
  input  wire logic [7:0] i_rdata
);
  logic [1:0] scl_sync_r;
  logic [1:0] sda_sync_r;
  logic       scl_d_r;
  logic       sda_d_r;
  logic [7:0] sh_r;
  logic [7:0] tx_r;
  logic [3:0] cnt_r;
  logic       rw_r;
  logic       first_r;
  lbs_pkg::lbs_ser_e state_r;
  logic scl_rise, scl_fall, start_c, stop_c;

  // --------------------------------------------------------------
  // pin synchronisers and edges
  // --------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      scl_sync_r <= 2'h3;
      sda_sync_r <= 2'h3;
      scl_d_r    <= 1'b1;
      sda_d_r    <= 1'b1;
    end else begin
      scl_sync_r <= {scl_sync_r[0], i_scl};
      sda_sync_r <= {sda_sync_r[0], i_sda};
      scl_d_r    <= scl_sync_r[1];
      sda_d_r    <= sda_sync_r[1];
    end
  end
  assign scl_rise = scl_sync_r[1] & ~scl_d_r;
  assign scl_fall = ~scl_sync_r[1] & scl_d_r;
  assign start_c  = scl_sync_r[1] & scl_d_r & sda_d_r & ~sda_sync_r[1];
  assign stop_c   = scl_sync_r[1] & scl_d_r & ~sda_d_r & sda_sync_r[1];
  assign o_sda_out = 1'b0;

  // --------------------------------------------------------------
  // protocol engine
  // --------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state_r  <= lbs_pkg::LBS_IDLE;
      sh_r     <= 8'h00;
      tx_r     <= 8'h00;
      cnt_r    <= 4'h0;
      rw_r     <= 1'b0;
      first_r  <= 1'b0;
      o_sda_oe <= 1'b0;
      o_addr   <= 8'h00;
      o_wdata  <= 8'h00;
      o_wr     <= 1'b0;
      o_rd     <= 1'b0;
    end else begin
      o_wr <= 1'b0;
      o_rd <= 1'b0;
      // pointer steps once the register file has taken the write
      if (o_wr) o_addr <= o_addr + 8'h01;
      if (start_c) begin
        state_r  <= lbs_pkg::LBS_DEV;
        cnt_r    <= 4'h0;
        o_sda_oe <= 1'b0;
      end else if (stop_c) begin
        state_r  <= lbs_pkg::LBS_IDLE;
        o_sda_oe <= 1'b0;
      end else if (scl_rise) begin
        sh_r  <= {sh_r[6:0], sda_sync_r[1]};
        cnt_r <= cnt_r + 4'h1;
      end else if (scl_fall) begin
        unique case (state_r)
          lbs_pkg::LBS_IDLE: ;
          lbs_pkg::LBS_DEV: if (cnt_r == 4'h8) begin
            cnt_r <= 4'h0;
            if (sh_r[7:1] == lbs_pkg::DEV_ADDR) begin
              o_sda_oe <= 1'b1;
              rw_r     <= sh_r[0];
              state_r  <= lbs_pkg::LBS_DACK;
            end else begin
              state_r <= lbs_pkg::LBS_IDLE;
            end
          end
          lbs_pkg::LBS_WBYTE: if (cnt_r == 4'h8) begin
            cnt_r    <= 4'h0;
            o_sda_oe <= 1'b1;
            state_r  <= lbs_pkg::LBS_WACK;
            if (first_r) begin
              o_addr  <= sh_r;
              first_r <= 1'b0;
            end else begin
              o_wdata <= sh_r;
              o_wr    <= 1'b1;
            end
          end
          lbs_pkg::LBS_WACK: begin
            o_sda_oe <= 1'b0;
            cnt_r    <= 4'h0;
            state_r  <= lbs_pkg::LBS_WBYTE;
          end
          lbs_pkg::LBS_RBYTE: begin
            if (cnt_r == 4'h8) begin
              o_sda_oe <= 1'b0;
              cnt_r    <= 4'h0;
              o_addr   <= o_addr + 8'h01;
              state_r  <= lbs_pkg::LBS_RACK;
            end else begin
              o_sda_oe <= ~tx_r[6];
              tx_r     <= {tx_r[6:0], 1'b0};
            end
          end
          lbs_pkg::LBS_DACK, lbs_pkg::LBS_RACK: begin
            cnt_r <= 4'h0;
            if (state_r == lbs_pkg::LBS_DACK && !rw_r) begin
              o_sda_oe <= 1'b0;
              first_r  <= 1'b1;
              state_r  <= lbs_pkg::LBS_WBYTE;
            end else if (state_r == lbs_pkg::LBS_RACK && sh_r[0]) begin
              o_sda_oe <= 1'b0;
              state_r  <= lbs_pkg::LBS_IDLE;
            end else begin
              // load next byte and put its msb on the line
              tx_r     <= i_rdata;
              o_sda_oe <= ~i_rdata[7];
              o_rd     <= 1'b1;
              state_r  <= lbs_pkg::LBS_RBYTE;
            end
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

/* File: core/lbs_bias_ctrl.sv */
// lbs_bias_ctrl: top of the lcd bias supply control block
// assumes pins and short detectors are asynchronous to i_clk
`timescale 1ns/10ps
`default_nettype none
module lbs_bias_ctrl #(
  parameter int P_FILT_2MS   = lbs_pkg::FILT_2MS_CYC,
  parameter int P_FILT_1MS   = lbs_pkg::FILT_1MS_CYC,
  parameter int P_FILT_500US = lbs_pkg::FILT_500US_CYC,
  parameter int P_RAMP_POS   = lbs_pkg::RAMP_POS_CYC,
  parameter int P_RAMP_NEG   = lbs_pkg::RAMP_NEG_CYC
) (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  // serial port
  input  wire logic i_scl,
  input  wire logic i_sda,
  output logic      o_sda_out,
  output logic      o_sda_oe,
  // enable pins and short detectors
  input  wire logic i_pos_enable_pin,
  input  wire logic i_neg_enable_pin,
  input  wire logic i_pos_overcurrent,
  input  wire logic i_neg_overcurrent,
  // supply controls
  output logic [2:0] o_bias_mode_select,
  output logic       o_pos_out_on,
  output logic       o_neg_out_on,
  output logic       o_pos_pulldown,
  output logic       o_neg_pulldown,
  output logic       o_pos_ramping,
  output logic       o_neg_ramping,
  output logic       o_backlight_off,
  output logic [5:0] o_bias_boost_voltage_code,
  output logic [5:0] o_positive_bias_code,
  output logic [5:0] o_negative_bias_code
);
  logic [7:0] en_cfg_r, ramp_cfg_r, filt_cfg_r, boost_r, pos_v_r, neg_v_r;
  logic [1:0] short_flag_r;
  logic       bias_shut_r;
  logic [1:0] pin_s1_r, pin_s2_r, oc_s1_r, oc_s2_r;
  logic [7:0] bus_addr, bus_wdata, rdata;
  logic       bus_wr, bus_rd, flags_rd;
  logic [1:0] short_evt;
  logic       mode_on, pos_en, neg_en;
  logic       pos_en_d_r, neg_en_d_r;
  logic [18:0] pos_ramp_r, neg_ramp_r;
  logic [18:0] pos_ramp_lim, neg_ramp_lim;
  logic [1:0]  filt_code [2];

  lbs_serial_port u_port (
    .i_clk     (i_clk),
    .i_rst_n   (i_rst_n),
    .i_scl     (i_scl),
    .i_sda     (i_sda),
    .o_sda_out (o_sda_out),
    .o_sda_oe  (o_sda_oe),
    .o_addr    (bus_addr),
    .o_wdata   (bus_wdata),
    .o_wr      (bus_wr),
    .o_rd      (bus_rd),
    .i_rdata   (rdata)
  );

  // --------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      pin_s1_r <= 2'h0;
      pin_s2_r <= 2'h0;
      oc_s1_r  <= 2'h0;
      oc_s2_r  <= 2'h0;
    end else begin
      pin_s1_r <= {i_neg_enable_pin, i_pos_enable_pin};
      pin_s2_r <= pin_s1_r;
      oc_s1_r  <= {i_neg_overcurrent, i_pos_overcurrent};
      oc_s2_r  <= oc_s1_r;
    end
  end

  // --------------------------------------------------------------
  // register file
  // --------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      en_cfg_r   <= lbs_pkg::RST_ENABLE_CFG;
      ramp_cfg_r <= lbs_pkg::RST_RAMP_SHORT;
      filt_cfg_r <= lbs_pkg::RST_FILTER_CFG;
      boost_r    <= lbs_pkg::RST_BOOST_V;
      pos_v_r    <= lbs_pkg::RST_POS_V;
      neg_v_r    <= lbs_pkg::RST_NEG_V;
    end else if (bus_wr) begin
      unique case (bus_addr)
        lbs_pkg::ADDR_ENABLE_CFG: en_cfg_r   <= bus_wdata;
        lbs_pkg::ADDR_RAMP_SHORT: ramp_cfg_r <= bus_wdata;
        lbs_pkg::ADDR_FILTER_CFG: filt_cfg_r <= bus_wdata & lbs_pkg::MASK_FILTER;
        lbs_pkg::ADDR_BOOST_V:    boost_r    <= bus_wdata & lbs_pkg::MASK_CODE;
        lbs_pkg::ADDR_POS_V:      pos_v_r    <= bus_wdata & lbs_pkg::MASK_CODE;
        lbs_pkg::ADDR_NEG_V:      neg_v_r    <= bus_wdata & lbs_pkg::MASK_CODE;
        default: ;
      endcase
    end
  end

  always_comb begin
    unique case (bus_addr)
      lbs_pkg::ADDR_ENABLE_CFG: rdata = en_cfg_r;
      lbs_pkg::ADDR_RAMP_SHORT: rdata = ramp_cfg_r;
      lbs_pkg::ADDR_FILTER_CFG: rdata = filt_cfg_r;
      lbs_pkg::ADDR_BOOST_V:    rdata = boost_r;
      lbs_pkg::ADDR_POS_V:      rdata = pos_v_r;
      lbs_pkg::ADDR_NEG_V:      rdata = neg_v_r;
      lbs_pkg::ADDR_FLAGS:      rdata = {4'h0, short_flag_r[0], short_flag_r[1], 2'h0};
      default:                  rdata = 8'h00;
    endcase
  end
  assign flags_rd = bus_rd && (bus_addr == lbs_pkg::ADDR_FLAGS);

  // --------------------------------------------------------------
  // mode decode and enable source
  // --------------------------------------------------------------
  always_comb begin
    unique case (en_cfg_r[lbs_pkg::MODE_MSB:lbs_pkg::MODE_LSB])
      lbs_pkg::MODE_NORMAL, lbs_pkg::MODE_AUTO,
      lbs_pkg::MODE_FIRST_WAKE_MODE, lbs_pkg::MODE_SECOND_WAKE_MODE: mode_on = 1'b1;
      default: mode_on = 1'b0;
    endcase
  end
  assign pos_en = mode_on & ~bias_shut_r & (en_cfg_r[lbs_pkg::BIT_PIN_SEL]
                  ? pin_s2_r[0]
                  : en_cfg_r[lbs_pkg::BIT_POS_EN]);
  assign neg_en = mode_on & ~bias_shut_r & (en_cfg_r[lbs_pkg::BIT_PIN_SEL]
                  ? pin_s2_r[1]
                  : en_cfg_r[lbs_pkg::BIT_NEG_EN]);

  // --------------------------------------------------------------
  // short filters, one per output
  // --------------------------------------------------------------
  assign filt_code[0] = filt_cfg_r[lbs_pkg::PFILT_LSB +: 2];
  assign filt_code[1] = filt_cfg_r[lbs_pkg::NFILT_LSB +: 2];
  for (genvar g = 0; g < 2; g++) begin : g_filt
    logic [16:0] cnt_r;
    logic [16:0] lim;
    always_comb begin
      unique case (filt_code[g])
        2'h0: lim = 17'(P_FILT_2MS - 1);
        2'h1: lim = 17'(P_FILT_1MS - 1);
        2'h2: lim = 17'(P_FILT_500US - 1);
        2'h3: lim = 17'(lbs_pkg::FILT_100US_CYC - 1);
      endcase
    end
    // count while the short holds, restart when it goes away
    always_ff @(posedge i_clk) begin
      if (!i_rst_n || !oc_s2_r[g]) begin
        cnt_r <= 17'h0;
      end else if (cnt_r <= lim) begin
        cnt_r <= cnt_r + 17'h1;
      end
    end
    assign short_evt[g] = oc_s2_r[g] && (cnt_r == lim);
  end

  // --------------------------------------------------------------
  // flags and short response
  // --------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      short_flag_r <= 2'h0;
    end else begin
      // a new event wins over the clear by read
      short_flag_r <= (flags_rd ? 2'h0 : short_flag_r) | short_evt;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      bias_shut_r     <= 1'b0;
      o_backlight_off <= 1'b0;
    end else if (|short_evt && ramp_cfg_r[lbs_pkg::SHORT_MSB]) begin
      bias_shut_r     <= 1'b1;
      o_backlight_off <= o_backlight_off | ramp_cfg_r[lbs_pkg::SHORT_LSB];
    end else if (flags_rd) begin
      bias_shut_r     <= 1'b0;
      o_backlight_off <= 1'b0;
    end
  end

  // --------------------------------------------------------------
  // ramp timers
  // --------------------------------------------------------------
  assign pos_ramp_lim = 19'((32'(ramp_cfg_r[lbs_pkg::PRAMP_MSB:lbs_pkg::PRAMP_LSB]) + 32'd1)
                        * P_RAMP_POS);
  assign neg_ramp_lim = 19'((32'(ramp_cfg_r[lbs_pkg::NRAMP_MSB:lbs_pkg::NRAMP_LSB]) + 32'd1)
                        * P_RAMP_NEG);

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      pos_en_d_r <= 1'b0;
      neg_en_d_r <= 1'b0;
      pos_ramp_r <= 19'h0;
      neg_ramp_r <= 19'h0;
    end else begin
      pos_en_d_r <= pos_en;
      neg_en_d_r <= neg_en;
      if (!pos_en)                  pos_ramp_r <= 19'h0;
      else if (!pos_en_d_r)         pos_ramp_r <= pos_ramp_lim;
      else if (pos_ramp_r != 19'h0) pos_ramp_r <= pos_ramp_r - 19'h1;
      if (!neg_en)                  neg_ramp_r <= 19'h0;
      else if (!neg_en_d_r)         neg_ramp_r <= neg_ramp_lim;
      else if (neg_ramp_r != 19'h0) neg_ramp_r <= neg_ramp_r - 19'h1;
    end
  end

  // --------------------------------------------------------------
  // registered outputs
  // --------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_bias_mode_select        <= lbs_pkg::MODE_OFF;
      o_pos_out_on              <= 1'b0;
      o_neg_out_on              <= 1'b0;
      o_pos_pulldown            <= 1'b0;
      o_neg_pulldown            <= 1'b0;
      o_pos_ramping             <= 1'b0;
      o_neg_ramping             <= 1'b0;
      o_bias_boost_voltage_code <= lbs_pkg::RST_BOOST_V[5:0];
      o_positive_bias_code      <= lbs_pkg::RST_POS_V[5:0];
      o_negative_bias_code      <= lbs_pkg::RST_NEG_V[5:0];
    end else begin
      o_bias_mode_select <= mode_on ? en_cfg_r[lbs_pkg::MODE_MSB:lbs_pkg::MODE_LSB]
                                    : lbs_pkg::MODE_OFF;
      o_pos_out_on   <= pos_en;
      o_neg_out_on   <= neg_en;
      o_pos_pulldown <= en_cfg_r[lbs_pkg::BIT_POS_DIS] & ~pos_en;
      o_neg_pulldown <= en_cfg_r[lbs_pkg::BIT_NEG_DIS] & ~neg_en;
      o_pos_ramping  <= pos_en && (!pos_en_d_r || pos_ramp_r > 19'h1);
      o_neg_ramping  <= neg_en && (!neg_en_d_r || neg_ramp_r > 19'h1);
      o_bias_boost_voltage_code <= boost_r[5:0];
      o_positive_bias_code <= (pos_v_r[5:0] > lbs_pkg::CODE_MAX)
                              ? lbs_pkg::CODE_MAX : pos_v_r[5:0];
      o_negative_bias_code <= (neg_v_r[5:0] > lbs_pkg::CODE_MAX)
                              ? lbs_pkg::CODE_MAX : neg_v_r[5:0];
    end
  end
endmodule
`default_nettype wire

/* File: tb/lbs_bias_ctrl_chk.sv */
// lbs_bias_ctrl_chk: port-level assertions for the bias supply control
// assumes it is bound into lbs_bias_ctrl with the same count parameters
`timescale 1ns/10ps
`default_nettype none
module lbs_bias_ctrl_chk #(
  parameter int P_FILT_500US = lbs_pkg::FILT_500US_CYC,
  parameter int P_RAMP_POS   = lbs_pkg::RAMP_POS_CYC,
  parameter int P_RAMP_NEG   = lbs_pkg::RAMP_NEG_CYC
) (
  input wire logic       i_clk,
  input wire logic       i_rst_n,
  input wire logic       i_pos_overcurrent,
  input wire logic       i_neg_overcurrent,
  input wire logic [2:0] o_bias_mode_select,
  input wire logic       o_pos_out_on,
  input wire logic       o_neg_out_on,
  input wire logic       o_pos_pulldown,
  input wire logic       o_neg_pulldown,
  input wire logic       o_pos_ramping,
  input wire logic       o_neg_ramping,
  input wire logic       o_backlight_off,
  input wire logic [5:0] o_positive_bias_code,
  input wire logic [5:0] o_negative_bias_code
);
  // --
  // helper counters
  // --
  localparam int MIN_FILT = (P_FILT_500US < lbs_pkg::FILT_100US_CYC) ?
                            P_FILT_500US : lbs_pkg::FILT_100US_CYC;
  logic [31:0] pr_cnt_r;
  logic [31:0] nr_cnt_r;
  logic [31:0] oc_cnt_r;
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || !o_pos_ramping) pr_cnt_r <= '0;
    else pr_cnt_r <= pr_cnt_r + 32'h1;
  end
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || !o_neg_ramping) nr_cnt_r <= '0;
    else nr_cnt_r <= nr_cnt_r + 32'h1;
  end
  // length of the latest detector run, held after it ends
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) oc_cnt_r <= '0;
    else if ((i_pos_overcurrent | i_neg_overcurrent) && !$past(i_pos_overcurrent | i_neg_overcurrent))
      oc_cnt_r <= 32'h1;
    else if (i_pos_overcurrent | i_neg_overcurrent) oc_cnt_r <= oc_cnt_r + 32'h1;
  end
  // --
  // properties
  // --
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);
  mode_code_a: assert property (!(o_bias_mode_select inside {3'h1, 3'h2, 3'h3}))
    else $error("reserved mode code on output");
  mode_on_a: assert property ((o_pos_out_on || o_neg_out_on) |-> o_bias_mode_select[2])
    else $error("output on while mode off");
  pos_pd_a: assert property (o_pos_out_on [*3] |-> !o_pos_pulldown)
    else $error("positive pulldown while on");
  neg_pd_a: assert property (o_neg_out_on [*3] |-> !o_neg_pulldown)
    else $error("negative pulldown while on");
  ramp_start_a: assert property ($rose(o_pos_out_on) |-> ##[0:2] o_pos_ramping)
    else $error("no positive ramp after enable");
  pos_ramp_a: assert property (pr_cnt_r <= 4 * P_RAMP_POS + 2)
    else $error("positive ramp too long");
  neg_ramp_a: assert property (nr_cnt_r <= 16 * P_RAMP_NEG + 2)
    else $error("negative ramp too long");
  bl_cut_a: assert property ($rose(o_backlight_off) |-> ##[0:2] !(o_pos_out_on || o_neg_out_on))
    else $error("bias left on with backlight cut");
  short_filt_a: assert property ($rose(o_backlight_off) |-> oc_cnt_r >= MIN_FILT)
    else $error("short response before filter time");
  pos_sat_a: assert property (o_positive_bias_code <= 6'h32)
    else $error("positive code above limit");
  neg_sat_a: assert property (o_negative_bias_code <= 6'h32)
    else $error("negative code above limit");
  cover property ($rose(o_backlight_off));
  cover property ($fell(o_neg_ramping));
  cover property ($fell(o_pos_out_on));
endmodule
bind lbs_bias_ctrl lbs_bias_ctrl_chk #(
  .P_FILT_500US(P_FILT_500US), .P_RAMP_POS(P_RAMP_POS), .P_RAMP_NEG(P_RAMP_NEG)
) u_chk (
  .i_clk, .i_rst_n, .i_pos_overcurrent, .i_neg_overcurrent, .o_bias_mode_select,
  .o_pos_out_on, .o_neg_out_on, .o_pos_pulldown, .o_neg_pulldown, .o_pos_ramping,
  .o_neg_ramping, .o_backlight_off, .o_positive_bias_code, .o_negative_bias_code
);
`default_nettype wire

/* File: tb/lbs_host_model.sv */
// lbs_host_model: two-wire host giving byte register access tasks
// assumes the bench resolves the data line with a pull-up
`timescale 1ns/10ps
`default_nettype none
module lbs_host_model (
  // clock
  input  wire logic i_clk,
  // serial pins
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda_low
);
  // --
  // bus cycles
  // --
  localparam int HALF = 10;
  initial begin
    o_scl     = 1'b1;
    o_sda_low = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  // start or repeated start, ends with clock low
  task automatic frame_start;
    o_sda_low = 1'b0;
    tick(HALF);
    o_scl = 1'b1;
    tick(HALF);
    o_sda_low = 1'b1;
    tick(HALF);
    o_scl = 1'b0;
    tick(4);
  endtask
  task automatic frame_stop;
    o_sda_low = 1'b1;
    tick(6);
    o_scl = 1'b1;
    tick(HALF);
    o_sda_low = 1'b0;
    tick(HALF);
  endtask
  // eight bits plus acknowledge, line level sampled late in the high phase
  task automatic bits9(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      o_sda_low = ~tx[i];
      tick(6);
      o_scl = 1'b1;
      tick(HALF);
      rx[i] = i_sda;
      o_scl = 1'b0;
      tick(4);
    end
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d, output logic nak);
    logic [8:0] r0;
    logic [8:0] r1;
    logic [8:0] r2;
    frame_start;
    bits9({lbs_pkg::DEV_ADDR, 1'b0, 1'b1}, r0);
    bits9({a, 1'b1}, r1);
    bits9({d, 1'b1}, r2);
    frame_stop;
    nak = r0[0] | r1[0] | r2[0];
  endtask
  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    logic [8:0] r;
    frame_start;
    bits9({lbs_pkg::DEV_ADDR, 1'b0, 1'b1}, r);
    bits9({a, 1'b1}, r);
    frame_start;
    bits9({lbs_pkg::DEV_ADDR, 1'b1, 1'b1}, r);
    bits9(9'h1ff, r);
    d = r[8:1];
    frame_stop;
  endtask
endmodule
`default_nettype wire

/* File: tb/lbs_bias_ctrl_tb.sv */
// lbs_bias_ctrl_tb: self-checking bench for the bias supply control
// assumes lbs_host_model for serial access; pins are driven from here
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin \
  checked++; \
  if ((got) !== (exp)) begin \
    err_total++; \
    $display("unexpected t=%0t got=%h exp=%h", $time, got, exp); \
  end \
end
module lbs_bias_ctrl_tb;
  // --
  // bench
  // --
  localparam int F2MS = 400;
  localparam int F1MS = 200;
  localparam int F500 = 100;
  localparam int RP   = 50;
  localparam int RN   = 100;
  int         err_total = 0;
  int         checked = 0;
  logic       clk, rst_n, scl, host_low, sda_oe, sda_out, pen, nen, poc, noc;
  logic       pon, non, ppd, npd, prmp, nrmp, blo;
  logic [2:0] mode;
  logic [5:0] boost, pcode, ncode;
  // open-drain line with pull-up: low only while a side drives a zero
  wire        sda = ~host_low & ~(sda_oe & ~sda_out);
  lbs_bias_ctrl #(
    .P_FILT_2MS(F2MS), .P_FILT_1MS(F1MS), .P_FILT_500US(F500),
    .P_RAMP_POS(RP), .P_RAMP_NEG(RN)
  ) uut (
    .i_clk(clk), .i_rst_n(rst_n), .i_scl(scl), .i_sda(sda),
    .o_sda_out(sda_out), .o_sda_oe(sda_oe),
    .i_pos_enable_pin(pen), .i_neg_enable_pin(nen),
    .i_pos_overcurrent(poc), .i_neg_overcurrent(noc),
    .o_bias_mode_select(mode), .o_pos_out_on(pon), .o_neg_out_on(non),
    .o_pos_pulldown(ppd), .o_neg_pulldown(npd), .o_pos_ramping(prmp),
    .o_neg_ramping(nrmp), .o_backlight_off(blo), .o_bias_boost_voltage_code(boost),
    .o_positive_bias_code(pcode), .o_negative_bias_code(ncode)
  );
  lbs_host_model host (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_low(host_low));
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic nk;
    host.reg_wr(a, d, nk);
    `CHK(nk, 1'b0)
  endtask
  task automatic summarize;
    $display("checked=%0d err_total=%0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // --
  // scenarios
  // --
  task automatic t_reset;
    logic [7:0] v;
    logic [7:0] e [7];
    e = '{8'h18, 8'h11, 8'h00, 8'h28, 8'h1e, 8'h1c, 8'h00};
    `CHK({boost, pcode, ncode}, {6'h28, 6'h1e, 6'h1c})
    `CHK({ppd, npd, pon, non}, 4'hc)
    for (int i = 0; i < 7; i++) begin
      host.reg_rd(8'h09 + i[7:0], v);
      `CHK(v, e[i])
    end
    wr(8'h0f, 8'hff);
    host.reg_rd(8'h0f, v);
    `CHK(v, 8'h00)
  endtask
  task automatic t_mode;
    logic [2:0] m;
    {pen, nen} = 2'b11;
    for (int i = 0; i < 8; i++) begin
      m = i[2:0];
      wr(8'h09, {m, 5'b00100});
      tick(2);
      `CHK(mode, m[2] ? m : 3'h0)
      `CHK({pon, non}, {m[2], 1'b0})
    end
    `CHK({ppd, npd}, 2'b00)
    wr(8'h09, 8'h9c);
    `CHK({ppd, npd}, 2'b01)
    wr(8'h09, 8'h87);
    {pen, nen} = 2'b00;
    tick(5);
    `CHK({pon, non}, 2'b00)
    {pen, nen} = 2'b10;
    tick(5);
    `CHK({pon, non}, 2'b10)
    {pen, nen} = 2'b01;
    tick(5);
    `CHK({pon, non}, 2'b01)
    {pen, nen} = 2'b00;
  endtask
  task automatic ramp_case(input logic [1:0] pc, input logic [3:0] nc);
    int np;
    int nn;
    np = 0;
    nn = 0;
    wr(8'h09, 8'h81);
    wr(8'h0a, {2'b00, pc, nc});
    {pen, nen} = 2'b11;
    for (int i = 0; i < 1700; i++) begin
      @(negedge clk);
      np += int'(prmp);
      nn += int'(nrmp);
    end
    {pen, nen} = 2'b00;
    tick(5);
    `CHK(np > (pc + 1) * RP - 3 && np < (pc + 1) * RP + 3, 1'b1)
    `CHK(nn > (nc + 1) * RN - 3 && nn < (nc + 1) * RN + 3, 1'b1)
  endtask
  task automatic t_codes;
    logic [5:0] c [4];
    c = '{6'h00, 6'h31, 6'h32, 6'h3f};
    for (int i = 0; i < 4; i++) begin
      wr(8'h0c, {2'b00, c[i]});
      wr(8'h0d, {2'b00, c[i]});
      wr(8'h0e, {2'b00, c[i]});
      `CHK(boost, c[i])
      `CHK(pcode, (c[i] > 6'h32) ? 6'h32 : c[i])
      `CHK(ncode, (c[i] > 6'h32) ? 6'h32 : c[i])
    end
  endtask
  task automatic t_short(input logic [1:0] sm, input logic [1:0] fc, input int n,
                         input logic neg);
    logic [7:0] v;
    wr(8'h0b, {2'b00, fc, 2'b00, fc});
    wr(8'h0a, {sm, 6'h00});
    wr(8'h09, 8'h86);
    {poc, noc} = {~neg, neg};
    tick(n - 10);
    {poc, noc} = 2'b00;
    host.reg_rd(8'h0f, v);
    `CHK(v, 8'h00)
    {poc, noc} = {~neg, neg};
    tick(n + 10);
    {poc, noc} = 2'b00;
    tick(2);
    `CHK({pon, non, blo}, {~sm[1], ~sm[1], &sm})
    host.reg_rd(8'h0f, v);
    `CHK(v, neg ? 8'h04 : 8'h08)
    host.reg_rd(8'h0f, v);
    `CHK({v, pon, non, blo}, {8'h00, 3'b110})
  endtask
  // --
  // run
  // --
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    // about 80k cycles, some 1.5 times the scenario total
    #2000000;
    err_total++;
    summarize;
  end
  initial begin
    rst_n = 1'b0;
    {pen, nen, poc, noc} = 4'h0;
    tick(6);
    rst_n = 1'b1;
    tick(1);
    t_reset;
    t_mode;
    ramp_case(2'h0, 4'hf);
    ramp_case(2'h3, 4'h0);
    t_codes;
    t_short(2'b10, 2'b10, F500, 1'b0);
    t_short(2'b11, 2'b01, F1MS, 1'b1);
    t_short(2'b01, 2'b00, F2MS, 1'b0);
    t_short(2'b00, 2'b11, 4000, 1'b1);
    summarize;
  end
endmodule
`default_nettype wire
